/* File: src/hpb_defines.svh */
`ifndef HPB_DEFINES_SVH
`define HPB_DEFINES_SVH

// ****************************************************************
// Timing
// ****************************************************************
// Core clock period and the half period used as the unit of waits
`define HPB_CLK_PERIOD_NS   4
`define HPB_HALF_PERIOD_NS  2
// Longest wait after a memory access, DMA busy and idle, and after a control write
`define HPB_DMA_WAIT_NS     (18 * `HPB_HALF_PERIOD_NS + 6)
`define HPB_IDLE_WAIT_NS    (10 * `HPB_HALF_PERIOD_NS + 6)
`define HPB_CTL_WAIT_NS     (6 * `HPB_HALF_PERIOD_NS + 6)
// Longest times round down to whole cycles, never below one
`define HPB_CYCLES(ns)      ((((ns) / `HPB_CLK_PERIOD_NS) < 1) ? 1 : ((ns) / `HPB_CLK_PERIOD_NS))
`define HPB_DMA_WAIT_CYC    `HPB_CYCLES(`HPB_DMA_WAIT_NS)
`define HPB_IDLE_WAIT_CYC   `HPB_CYCLES(`HPB_IDLE_WAIT_NS)
`define HPB_CTL_WAIT_CYC    `HPB_CYCLES(`HPB_CTL_WAIT_NS)

// ****************************************************************
// Control register
// ****************************************************************
`define HPB_CTL_RESET       8'h00
`define HPB_CTL_CORE_BIT    2
`define HPB_CTL_HOST_BIT    3

// ****************************************************************
// Other reset values
// ****************************************************************
`define HPB_ADDR_RESET      16'h0000
`define HPB_WORD_RESET      16'h0000
`define HPB_BYTE_RESET      8'h00

`endif

/* File: src/hpb_host_port.sv */
`include "hpb_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module hpb_host_port
	import hpb_pkg::*;
#(
	parameter int ADDR_W = 16,
	parameter int WAIT_W = 4
) (
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              rstn,
	// Host strobes and control pins
	input  wire logic              port_select_n,
	input  wire logic              data_strobe_a_n,
	input  wire logic              data_strobe_b_n,
	input  wire logic              addr_strobe_n,
	input  wire logic              byte_identifier,
	input  wire logic              ctl_select_lo,
	input  wire logic              ctl_select_hi,
	input  wire logic              read_write_sel,
	// Host byte bus, split
	input  wire logic [7:0]        host_byte_bus_in,
	output logic      [7:0]        host_byte_bus_out,
	output logic      [7:0]        host_byte_bus_oe,
	// Handshake and interrupt to the host
	output logic                   host_ready_out,
	output logic                   host_irq_out,
	// Core side
	input  wire logic              core_host_irq_set,
	output logic                   core_wakeup_request,
	input  wire logic              dma_active,
	// Internal memory access
	output logic                   mem_req,
	output logic                   mem_we,
	output logic      [ADDR_W-1:0] mem_addr,
	output logic      [15:0]       mem_wdata,
	input  wire logic [15:0]       mem_rdata,
	input  wire logic              mem_ack,
	// General-purpose use of the byte bus
	input  wire logic              gpio_enable,
	input  wire logic [7:0]        gpio_dir,
	input  wire logic [7:0]        gpio_out_value,
	output logic      [7:0]        gpio_in_value
);

	localparam logic [WAIT_W-1:0] DMA_WAIT  = WAIT_W'(`HPB_DMA_WAIT_CYC);
	localparam logic [WAIT_W-1:0] IDLE_WAIT = WAIT_W'(`HPB_IDLE_WAIT_CYC);
	localparam logic [WAIT_W-1:0] CTL_WAIT  = WAIT_W'(`HPB_CTL_WAIT_CYC);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [7:0]        pin_s1_reg;
	logic [7:0]        pin_s2_reg;
	logic [7:0]        data_s1_reg;
	logic [7:0]        data_s2_reg;
	logic              cs_s, dsa_s, dsb_s, as_s, bid_s, sel_lo_s, sel_hi_s, rw_s;

	// Two flops on every pin before any logic looks at it
	always_ff @(posedge clock) begin
		if (!rstn) begin
			pin_s1_reg  <= 8'hFF;
			pin_s2_reg  <= 8'hFF;
			data_s1_reg <= `HPB_BYTE_RESET;
			data_s2_reg <= `HPB_BYTE_RESET;
		end else begin
			pin_s1_reg  <= {port_select_n, data_strobe_a_n, data_strobe_b_n, addr_strobe_n,
				byte_identifier, ctl_select_lo, ctl_select_hi, read_write_sel};
			pin_s2_reg  <= pin_s1_reg;
			data_s1_reg <= host_byte_bus_in;
			data_s2_reg <= data_s1_reg;
		end
	end

	assign {cs_s, dsa_s, dsb_s, as_s, bid_s, sel_lo_s, sel_hi_s, rw_s} = pin_s2_reg;

	// ****************************************************************
	// Strobe edges and address latch
	// ****************************************************************
	logic              combined_transfer_strobe;
	logic              strobe_reg;
	logic              as_reg;
	logic              bid_latch_reg;
	logic              strobe_fall, strobe_rise, as_fall;
	logic              bid_now;
	hpb_sel_t          sel_now;
	hpb_sel_t          sel_reg;
	logic              rw_reg;
	logic              bid_reg;

	assign combined_transfer_strobe = cs_s | dsa_s | dsb_s;
	assign strobe_fall = strobe_reg & ~combined_transfer_strobe;
	assign strobe_rise = ~strobe_reg & combined_transfer_strobe;
	assign as_fall     = as_reg & ~as_s;
	// A held-low address strobe means its latched byte id governs this access
	assign bid_now     = as_s ? bid_s : bid_latch_reg;
	assign sel_now     = hpb_sel_t'({sel_hi_s, sel_lo_s});

	// Edge history, and the access attributes taken at strobe fall
	always_ff @(posedge clock) begin
		if (!rstn) begin
			strobe_reg    <= 1'b1;
			as_reg        <= 1'b1;
			bid_latch_reg <= 1'b0;
			sel_reg       <= HPB_SEL_CTL;
			rw_reg        <= 1'b1;
			bid_reg       <= 1'b0;
		end else begin
			strobe_reg <= combined_transfer_strobe;
			as_reg     <= as_s;
			if (as_fall) begin
				bid_latch_reg <= bid_s;
			end
			if (strobe_fall) begin
				sel_reg <= sel_now;
				rw_reg  <= rw_s;
				bid_reg <= bid_now;
			end
		end
	end

	// ****************************************************************
	// Access sequencer
	// ****************************************************************
	hpb_state_t        state_reg, state_next;
	logic [WAIT_W-1:0] wait_cnt_reg;
	logic              mem_done_reg;
	logic              is_data_rd_first, is_data_wr_second, is_ctl_wr_irq;
	logic              data_sel;

	assign data_sel          = (sel_reg == HPB_SEL_DATA) || (sel_reg == HPB_SEL_DATA_INC);
	assign is_data_rd_first  = strobe_fall && rw_s && !bid_now &&
		((sel_now == HPB_SEL_DATA) || (sel_now == HPB_SEL_DATA_INC));
	assign is_data_wr_second = strobe_rise && !rw_reg && bid_reg && data_sel;
	assign is_ctl_wr_irq     = strobe_rise && !rw_reg && (sel_reg == HPB_SEL_CTL) &&
		(data_s2_reg[`HPB_CTL_CORE_BIT] || data_s2_reg[`HPB_CTL_HOST_BIT]);

	// Next state
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			HPB_IDLE: begin
				if (is_data_rd_first) begin
					state_next = HPB_RD_FETCH;
				end else if (is_data_wr_second) begin
					state_next = HPB_WR_WAIT;
				end else if (is_ctl_wr_irq) begin
					state_next = HPB_CTL_WAIT;
				end
			end
			HPB_RD_FETCH: begin
				if (mem_ack) begin
					state_next = HPB_IDLE;
				end
			end
			HPB_WR_WAIT: begin
				if ((mem_done_reg || mem_ack) && wait_cnt_reg <= WAIT_W'(1)) begin
					state_next = HPB_IDLE;
				end
			end
			HPB_CTL_WAIT: begin
				if (wait_cnt_reg <= WAIT_W'(1)) begin
					state_next = HPB_IDLE;
				end
			end
		endcase
	end

	// State, wait counter and completion flag
	always_ff @(posedge clock) begin
		if (!rstn) begin
			state_reg    <= HPB_IDLE;
			wait_cnt_reg <= '0;
			mem_done_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (state_reg == HPB_IDLE && is_data_wr_second) begin
				wait_cnt_reg <= dma_active ? DMA_WAIT : IDLE_WAIT;
				mem_done_reg <= 1'b0;
			end else if (state_reg == HPB_IDLE && is_ctl_wr_irq) begin
				wait_cnt_reg <= CTL_WAIT;
			end else begin
				if (wait_cnt_reg != '0) begin
					wait_cnt_reg <= wait_cnt_reg - WAIT_W'(1);
				end
				if (mem_ack) begin
					mem_done_reg <= 1'b1;
				end
			end
		end
	end

	// ****************************************************************
	// Registers behind the port
	// ****************************************************************
	logic [7:0]        host_control_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic [7:0]        wr_hi_reg;
	logic [15:0]       rd_word_reg;
	logic              do_inc;

	// Autoincrement after the second byte of a data word on the increment selection
	assign do_inc = strobe_rise && bid_reg && (sel_reg == HPB_SEL_DATA_INC);

	// Address register, first byte is the upper one
	always_ff @(posedge clock) begin
		if (!rstn) begin
			addr_reg <= ADDR_W'(`HPB_ADDR_RESET);
		end else if (strobe_rise && !rw_reg && sel_reg == HPB_SEL_ADDR) begin
			if (bid_reg) begin
				addr_reg <= ADDR_W'({addr_reg[15:8], data_s2_reg});
			end else begin
				addr_reg <= ADDR_W'({data_s2_reg, addr_reg[7:0]});
			end
		end else if (do_inc) begin
			addr_reg <= addr_reg + ADDR_W'(1);
		end
	end

	// First write byte held until the second completes the word
	always_ff @(posedge clock) begin
		if (!rstn) begin
			wr_hi_reg <= `HPB_BYTE_RESET;
		end else if (strobe_rise && !rw_reg && !bid_reg && data_sel) begin
			wr_hi_reg <= data_s2_reg;
		end
	end

	// Control register; host bit clears on a one, core event sets it, set wins
	always_ff @(posedge clock) begin
		if (!rstn) begin
			host_control_reg <= `HPB_CTL_RESET;
		end else begin
			if (strobe_rise && !rw_reg && sel_reg == HPB_SEL_CTL) begin
				host_control_reg <= data_s2_reg;
				host_control_reg[`HPB_CTL_CORE_BIT] <= 1'b0;
				host_control_reg[`HPB_CTL_HOST_BIT] <= host_control_reg[`HPB_CTL_HOST_BIT] &
					~data_s2_reg[`HPB_CTL_HOST_BIT];
			end
			if (core_host_irq_set) begin
				host_control_reg[`HPB_CTL_HOST_BIT] <= 1'b1;
			end
		end
	end

	// Interrupt to host and wake pulse to the core, both from flops
	always_ff @(posedge clock) begin
		if (!rstn) begin
			host_irq_out        <= 1'b0;
			core_wakeup_request <= 1'b0;
		end else begin
			host_irq_out        <= host_control_reg[`HPB_CTL_HOST_BIT];
			core_wakeup_request <= strobe_rise && !rw_reg && sel_reg == HPB_SEL_CTL &&
				data_s2_reg[`HPB_CTL_CORE_BIT];
		end
	end

	// Memory request: write on second byte, prefetch on first read byte
	always_ff @(posedge clock) begin
		if (!rstn) begin
			mem_req   <= 1'b0;
			mem_we    <= 1'b0;
			mem_addr  <= '0;
			mem_wdata <= `HPB_WORD_RESET;
		end else begin
			mem_req <= (state_reg == HPB_IDLE) && (is_data_wr_second || is_data_rd_first);
			if (state_reg == HPB_IDLE && is_data_wr_second) begin
				mem_we    <= 1'b1;
				mem_addr  <= addr_reg;
				mem_wdata <= {wr_hi_reg, data_s2_reg};
			end else if (state_reg == HPB_IDLE && is_data_rd_first) begin
				mem_we   <= 1'b0;
				mem_addr <= addr_reg;
			end
		end
	end

	// Prefetched word
	always_ff @(posedge clock) begin
		if (!rstn) begin
			rd_word_reg <= `HPB_WORD_RESET;
		end else if (state_reg == HPB_RD_FETCH && mem_ack) begin
			rd_word_reg <= mem_rdata;
		end
	end

	// ****************************************************************
	// Byte bus, ready and general-purpose pins
	// ****************************************************************
	logic [7:0]        rd_byte;

	// Byte for a register read or a second data byte, valid at once
	always_comb begin
		rd_byte = `HPB_BYTE_RESET;
		unique case (sel_now)
			HPB_SEL_CTL:  rd_byte = host_control_reg;
			HPB_SEL_ADDR: rd_byte = bid_now ? addr_reg[7:0] : 8'(addr_reg >> 8);
			default:      rd_byte = bid_now ? rd_word_reg[7:0] : rd_word_reg[15:8];
		endcase
	end

	// Drive from strobe fall to strobe rise on reads; in GPIO mode follow the direction bits
	always_ff @(posedge clock) begin
		if (!rstn) begin
			host_byte_bus_out <= `HPB_BYTE_RESET;
			host_byte_bus_oe  <= 8'h00;
		end else if (gpio_enable) begin
			host_byte_bus_out <= gpio_out_value;
			host_byte_bus_oe  <= gpio_dir;
		end else if (strobe_fall && rw_s) begin
			host_byte_bus_out <= rd_byte;
			host_byte_bus_oe  <= 8'hFF;
		end else if (combined_transfer_strobe) begin
			host_byte_bus_oe  <= 8'h00;
		end else if (state_reg == HPB_RD_FETCH && mem_ack) begin
			host_byte_bus_out <= mem_rdata[15:8];
		end
	end

	// Inputs sampled on the core clock only
	always_ff @(posedge clock) begin
		if (!rstn) begin
			gpio_in_value <= `HPB_BYTE_RESET;
		end else begin
			gpio_in_value <= data_s2_reg;
		end
	end

	// Ready low while a wait is pending, forced high when deselected
	always_ff @(posedge clock) begin
		if (!rstn) begin
			host_ready_out <= 1'b1;
		end else begin
			host_ready_out <= cs_s || (state_next == HPB_IDLE);
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	a_ready_when_deselected: assert property (cs_s |=> host_ready_out)
		else $error("ready low while deselected");
	a_bus_released: assert property (combined_transfer_strobe && !gpio_enable
		|=> host_byte_bus_oe == 8'h00)
		else $error("byte bus driven with strobe high");
	a_bus_driven_read: assert property (strobe_fall && rw_s && !gpio_enable
		|=> host_byte_bus_oe == 8'hFF)
		else $error("byte bus not driven on read");
	a_write_wait_load: assert property (state_reg == HPB_IDLE && is_data_wr_second
		|=> wait_cnt_reg == (($past(dma_active)) ? DMA_WAIT : IDLE_WAIT))
		else $error("wrong memory wait length");
	a_write_holds_ready: assert property (state_reg == HPB_IDLE && is_data_wr_second && !cs_s
		##1 !cs_s |-> !host_ready_out)
		else $error("ready not dropped after memory write");
	a_ctl_wait_len: assert property (state_reg == HPB_IDLE && is_ctl_wr_irq
		|=> state_reg == HPB_CTL_WAIT ##[1:5] state_reg == HPB_IDLE)
		else $error("control wait wrong length");
	a_plain_ctl_write: assert property (strobe_rise && !rw_reg && sel_reg == HPB_SEL_CTL &&
		!is_ctl_wr_irq && state_reg == HPB_IDLE |=> state_reg == HPB_IDLE)
		else $error("plain control write caused a wait");
	a_wakeup_pulse: assert property (core_wakeup_request |=> !core_wakeup_request)
		else $error("wake request longer than one cycle");
	a_irq_set_wins: assert property (core_host_irq_set |=> ##1 host_irq_out)
		else $error("host interrupt lost");
	a_gpio_follows: assert property (gpio_enable |=> host_byte_bus_oe == $past(gpio_dir))
		else $error("gpio direction not applied");
	a_fetch_ready_low: assert property (state_reg == HPB_RD_FETCH && !mem_ack && !cs_s
		|=> !host_ready_out)
		else $error("ready high during prefetch");

	c_mem_write: cover property (state_reg == HPB_WR_WAIT ##[1:12] state_reg == HPB_IDLE);
	c_prefetch:  cover property (state_reg == HPB_RD_FETCH ##1 state_reg == HPB_IDLE);
	c_ctl_wait:  cover property (state_reg == HPB_CTL_WAIT);
	c_deselect:  cover property (!cs_s ##1 cs_s);

endmodule : hpb_host_port

`default_nettype wire

/* File: src/hpb_pkg.sv */
// ****************************************************************
// Types of the host byte port
// ****************************************************************
package hpb_pkg;

	// Port states, one-hot
	typedef enum logic [3:0] {
		HPB_IDLE     = 4'b0001,
		HPB_RD_FETCH = 4'b0010,
		HPB_WR_WAIT  = 4'b0100,
		HPB_CTL_WAIT = 4'b1000
	} hpb_state_t;

	// Register chosen by the two control-select lines {hi, lo}
	typedef enum logic [1:0] {
		HPB_SEL_CTL      = 2'h0,
		HPB_SEL_DATA_INC = 2'h1,
		HPB_SEL_ADDR     = 2'h2,
		HPB_SEL_DATA     = 2'h3
	} hpb_sel_t;

endpackage : hpb_pkg

/* File: tb/hpb_host_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Host processor on the far side of the byte port
// ****************************************************************
module hpb_host_model (
	// Clock
	input  wire logic       clock,
	// Strobes and control toward the port
	output logic            port_select_n,
	output logic            data_strobe_a_n,
	output logic            data_strobe_b_n,
	output logic            addr_strobe_n,
	output logic            byte_identifier,
	output logic            ctl_select_lo,
	output logic            ctl_select_hi,
	output logic            read_write_sel,
	// Byte bus as the port sees it
	output logic      [7:0] host_byte_bus_in,
	// Answers from the port
	input  wire logic [7:0] host_byte_bus_out,
	input  wire logic [7:0] host_byte_bus_oe,
	input  wire logic       host_ready_out
);
	logic [7:0] drv_val;
	logic       drv_en;
	logic [7:0] last_q;
	int         hang_count;

	// Idle levels: deselected, strobes high
	initial begin
		{port_select_n, data_strobe_a_n, data_strobe_b_n, addr_strobe_n} = 4'hF;
		{byte_identifier, ctl_select_lo, ctl_select_hi, read_write_sel} = 4'h0;
		drv_val = 8'h00;
		drv_en = 1'b0;
		last_q = 8'h00;
		hang_count = 0;
	end

	// Bits nobody drives flip every cycle so a stale byte never looks valid
	always @(posedge clock) last_q <= host_byte_bus_in;
	assign host_byte_bus_in = (host_byte_bus_oe & host_byte_bus_out)
		| (~host_byte_bus_oe & (drv_en ? drv_val : ~last_q));

	// Wait for ready under a bound; a stuck port is counted, not waited on
	task automatic wait_ready();
		int i;
		i = 0;
		do begin
			@(posedge clock);
			i++;
		end while (host_ready_out !== 1'b1 && i < 80);
		if (i >= 80) hang_count++;
	endtask : wait_ready

	// Drive the bus pins directly, as in general-purpose use
	task automatic drive_bus(input logic en, input logic [7:0] val);
		@(posedge clock);
		drv_en <= en;
		drv_val <= val;
	endtask : drive_bus

	// One byte transfer; strobes selects which data strobes go low
	task automatic xfer(input logic rw, input logic [1:0] sel, input logic bid,
		input logic [7:0] wd, input logic use_as, input logic [1:0] strobes,
		output logic [7:0] rd);
		@(posedge clock);
		port_select_n <= 1'b0;
		read_write_sel <= rw;
		{ctl_select_hi, ctl_select_lo} <= sel;
		byte_identifier <= bid;
		drv_en <= !rw;
		drv_val <= wd;
		addr_strobe_n <= !use_as;
		@(posedge clock);
		data_strobe_a_n <= !strobes[0];
		data_strobe_b_n <= !strobes[1];
		// With the address strobe low the pin may move; the latched value counts
		if (use_as) byte_identifier <= !bid;
		repeat (3) @(posedge clock);
		wait_ready();
		rd = host_byte_bus_in;
		{data_strobe_a_n, data_strobe_b_n, addr_strobe_n} <= 3'h7;
		// Write data held past the rising edge until it is surely captured
		repeat (3) @(posedge clock);
		drv_en <= 1'b0;
		repeat (2) @(posedge clock);
		wait_ready();
		port_select_n <= 1'b1;
		repeat (3) @(posedge clock);
	endtask : xfer

endmodule : hpb_host_model

`default_nettype wire

/* File: tb/hpb_host_port_tb.sv */
`timescale 1ns/10ps
`include "hpb_defines.svh"
`default_nettype none

// ****************************************************************
// Self-checking bench of the host byte port
// ****************************************************************
module hpb_host_port_tb;
	logic clock = 1'b0, rstn = 1'b0;
	logic port_select_n, data_strobe_a_n, data_strobe_b_n, addr_strobe_n;
	logic byte_identifier, ctl_select_lo, ctl_select_hi, read_write_sel;
	logic [7:0] host_byte_bus_in, host_byte_bus_out, host_byte_bus_oe;
	logic host_ready_out, host_irq_out, core_wakeup_request, mem_req, mem_we;
	logic core_host_irq_set = 1'b0, dma_active = 1'b0, mem_ack = 1'b0;
	logic [15:0] mem_addr, mem_wdata, mem_rdata = 16'h0000, last_waddr, last_wdata;
	logic gpio_enable = 1'b0;
	logic [7:0] gpio_dir = 8'h00, gpio_out_value = 8'h00, gpio_in_value;
	logic [15:0] mem_arr [256];
	logic [7:0] req_idx, rd, v, rv;
	logic [15:0] a, w;
	logic [7:0] vals [3];
	int wait_cnt = 0, low_cnt = 0, wake_cnt = 0, wr_count = 0;
	int miscompares = 0, cmp_count = 0, k, n0, n1, d;

	always #2 clock = ~clock;

	hpb_host_port dut_u (.clock(clock), .rstn(rstn), .port_select_n(port_select_n),
		.data_strobe_a_n(data_strobe_a_n), .data_strobe_b_n(data_strobe_b_n),
		.addr_strobe_n(addr_strobe_n), .byte_identifier(byte_identifier),
		.ctl_select_lo(ctl_select_lo), .ctl_select_hi(ctl_select_hi),
		.read_write_sel(read_write_sel), .host_byte_bus_in(host_byte_bus_in),
		.host_byte_bus_out(host_byte_bus_out), .host_byte_bus_oe(host_byte_bus_oe),
		.host_ready_out(host_ready_out), .host_irq_out(host_irq_out),
		.core_host_irq_set(core_host_irq_set), .core_wakeup_request(core_wakeup_request),
		.dma_active(dma_active), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
		.gpio_enable(gpio_enable), .gpio_dir(gpio_dir), .gpio_out_value(gpio_out_value),
		.gpio_in_value(gpio_in_value));

	hpb_host_model host_u (.clock(clock), .port_select_n(port_select_n),
		.data_strobe_a_n(data_strobe_a_n), .data_strobe_b_n(data_strobe_b_n),
		.addr_strobe_n(addr_strobe_n), .byte_identifier(byte_identifier),
		.ctl_select_lo(ctl_select_lo), .ctl_select_hi(ctl_select_hi),
		.read_write_sel(read_write_sel), .host_byte_bus_in(host_byte_bus_in),
		.host_byte_bus_out(host_byte_bus_out), .host_byte_bus_oe(host_byte_bus_oe),
		.host_ready_out(host_ready_out));

	// Memory answers after a random 1 to 3 cycles; read data is scrambled off ack
	always @(posedge clock) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_req === 1'b1) begin
			wait_cnt <= $urandom_range(1, 3);
			req_idx <= mem_addr[7:0];
			if (mem_we) begin
				mem_arr[mem_addr[7:0]] <= mem_wdata;
				last_waddr <= mem_addr;
				last_wdata <= mem_wdata;
				wr_count <= wr_count + 1;
			end
		end else if (wait_cnt != 0) begin
			wait_cnt <= wait_cnt - 1;
			if (wait_cnt == 1) begin
				mem_ack <= 1'b1;
				mem_rdata <= mem_arr[req_idx];
			end
		end
	end

	// Running counts of ready-low cycles and wake pulses
	always @(posedge clock) begin
		if (host_ready_out === 1'b0) low_cnt <= low_cnt + 1;
		if (core_wakeup_request === 1'b1) wake_cnt <= wake_cnt + 1;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic close_out();
		$display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : close_out

	// Every transfer starts from a deselected port, where ready must be high
	task automatic xf(input logic rw, input logic [1:0] sel, input logic bid,
		input logic [7:0] wd, input logic use_as, input logic [1:0] stb);
		chk(16'(host_ready_out), 16'h0001);
		host_u.xfer(rw, sel, bid, wd, use_as, stb, rd);
	endtask : xf

	// Watchdog, far beyond the thousand or so cycles the tests need
	initial begin
		repeat (20000) @(posedge clock);
		miscompares++;
		close_out();
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		void'($urandom(26));
		repeat (12) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		// Word write and read back through address and data registers
		for (k = 0; k < 6; k++) begin
			a = 16'($urandom_range(0, 255));
			w = 16'($urandom);
			dma_active <= k[0];
			xf(1'b0, 2'h2, 1'b0, a[15:8], k == 1, 2'h3);
			xf(1'b0, 2'h2, 1'b1, a[7:0], 1'b0, 2'h3);
			xf(1'b0, 2'h3, 1'b0, w[15:8], 1'b0, 2'h3);
			n0 = low_cnt;
			xf(1'b0, 2'h3, 1'b1, w[7:0], 1'b0, 2'h3);
			d = low_cnt - n0;
			chk(last_waddr, a);
			chk(last_wdata, w);
			if (k[0]) chk(16'(d > `HPB_IDLE_WAIT_CYC && d <= `HPB_DMA_WAIT_CYC + 2), 16'h0001);
			else chk(16'(d >= 1 && d <= `HPB_IDLE_WAIT_CYC + 2), 16'h0001);
			xf(1'b1, 2'h3, 1'b0, 8'h00, 1'b0, 2'h3);
			chk({8'h00, rd}, {8'h00, w[15:8]});
			xf(1'b1, 2'h3, 1'b1, 8'h00, 1'b0, 2'h3);
			chk({8'h00, rd}, {8'h00, w[7:0]});
			chk({8'h00, host_byte_bus_oe}, 16'h0000);
			xf(1'b1, 2'h2, 1'b1, 8'h00, 1'b0, 2'h3);
			chk({8'h00, rd}, {8'h00, a[7:0]});
			$display("word test %0d done", k);
		end
		// Data write on the increment selection steps the address after the second byte
		xf(1'b0, 2'h1, 1'b0, 8'h5A, 1'b0, 2'h3);
		xf(1'b0, 2'h1, 1'b1, 8'hA5, 1'b0, 2'h3);
		chk(last_waddr, a);
		chk(last_wdata, 16'h5AA5);
		xf(1'b1, 2'h2, 1'b1, 8'h00, 1'b0, 2'h3);
		chk({8'h00, rd}, {8'h00, 8'(a[7:0] + 8'h01)});
		$display("increment test done");
		// A single data strobe low must not start a transfer
		for (k = 1; k < 3; k++) begin
			n0 = wr_count;
			xf(1'b0, 2'h3, 1'b1, 8'($urandom), 1'b0, k[1:0]);
			chk(16'(wr_count - n0), 16'h0000);
		end
		$display("strobe test done");
		// Core raises the host interrupt, then control writes of each kind
		@(posedge clock);
		core_host_irq_set <= 1'b1;
		@(posedge clock);
		core_host_irq_set <= 1'b0;
		repeat (3) @(posedge clock);
		chk(16'(host_irq_out), 16'h0001);
		vals = '{8'h04, 8'h08, 8'($urandom) & 8'hF3};
		for (k = 0; k < 3; k++) begin
			v = vals[k];
			n0 = low_cnt;
			n1 = wake_cnt;
			xf(1'b0, 2'h0, 1'b1, v, 1'b0, 2'h3);
			d = low_cnt - n0;
			if (v[3:2] != 2'h0) chk(16'(d >= 1 && d <= `HPB_CTL_WAIT_CYC + 2), 16'h0001);
			else chk(16'(d), 16'h0000);
			chk(16'(wake_cnt - n1), {15'h0000, v[2]});
		end
		chk(16'(host_irq_out), 16'h0000);
		$display("control test done");
		// General-purpose use: upper pins out, lower pins in
		v = 8'($urandom);
		rv = 8'($urandom);
		host_u.drive_bus(1'b1, rv);
		gpio_out_value <= v;
		gpio_dir <= 8'hF0;
		gpio_enable <= 1'b1;
		repeat (6) @(posedge clock);
		chk({8'h00, host_byte_bus_oe}, 16'h00F0);
		chk({8'h00, host_byte_bus_out & 8'hF0}, {8'h00, v & 8'hF0});
		chk({8'h00, gpio_in_value}, {8'h00, (v & 8'hF0) | (rv & 8'h0F)});
		gpio_enable <= 1'b0;
		host_u.drive_bus(1'b0, 8'h00);
		repeat (3) @(posedge clock);
		chk(16'(host_u.hang_count), 16'h0000);
		$display("general-purpose test done");
		close_out();
	end

endmodule : hpb_host_port_tb

`default_nettype wire
